//--- logic/ebl_pkg.sv
// ebl_pkg: opcodes, T-state counts, flag positions and reset values
// for the 8-bit load executor; assumes one T-state per clock cycle.
package ebl_pkg;

   // prefix and opcode bytes
   localparam logic [7:0] OP_PFX_X      = 8'hdd;
   localparam logic [7:0] OP_PFX_Y      = 8'hfd;
   localparam logic [7:0] OP_PFX_E      = 8'hed;
   localparam logic [7:0] OP_ST_IDX_IMM = 8'h36;
   localparam logic [7:0] OP_LD_A_P1    = 8'h0a;
   localparam logic [7:0] OP_LD_A_P2    = 8'h1a;
   localparam logic [7:0] OP_LD_A_DIR   = 8'h3a;
   localparam logic [7:0] OP_ST_A_P1    = 8'h02;
   localparam logic [7:0] OP_ST_A_P2    = 8'h12;
   localparam logic [7:0] OP_ST_A_DIR   = 8'h32;
   localparam logic [7:0] OP_LD_A_IVP   = 8'h57;
   localparam logic [7:0] OP_LD_A_RFC   = 8'h5f;
   localparam logic [7:0] OP_LD_IVP_A   = 8'h47;
   localparam logic [7:0] OP_LD_RFC_A   = 8'h4f;

   // clock states per machine cycle
   localparam logic [2:0] T_FETCH       = 3'h4;
   localparam logic [2:0] T_MEM         = 3'h3;
   localparam logic [2:0] T_IDX_CALC    = 3'h5;
   localparam logic [2:0] T_SPECIAL     = 3'h5;

   // flag bit positions
   localparam int FLAG_C  = 0;
   localparam int FLAG_N  = 1;
   localparam int FLAG_PV = 2;
   localparam int FLAG_H  = 4;
   localparam int FLAG_Z  = 6;
   localparam int FLAG_S  = 7;

   // reset values
   localparam logic [15:0] RST_PC    = 16'h0000;
   localparam logic [7:0]  RST_ACC   = 8'hff;
   localparam logic [7:0]  RST_FLAGS = 8'hff;
   localparam logic [7:0]  RST_IVP   = 8'h00;
   localparam logic [7:0]  RST_RFC   = 8'h00;
   localparam logic [2:0]  RST_TNUM  = 3'h1;

   // machine-cycle sequencer states
   typedef enum logic [2:0] {
      ST_FETCH,
      ST_FETCH_PFX,
      ST_DISP,
      ST_IMM,
      ST_ADDR_LO,
      ST_ADDR_HI,
      ST_MEM_RD,
      ST_MEM_WR
   } ebl_state_t;

endpackage : ebl_pkg

//--- logic/ebl_tick_if.sv
// ebl_tick_if: length of the running machine cycle and its last state
// assumes both ends share one clock
`timescale 1ns/1ps
interface ebl_tick_if;
   logic [2:0] len;
   logic       last;
   logic [2:0] tnum;

   modport timer (input len, output last, output tnum);
   modport ctrl  (output len, input last, input tnum);
endinterface : ebl_tick_if

//--- logic/ebl_tstate_timer.sv
// ebl_tstate_timer: counts clock states 1..len of each machine cycle
// assumes len changes only on the edge that ends a cycle
`timescale 1ns/1ps
module ebl_tstate_timer (
   // clock and control
   input  wire logic  clock,
   input  wire logic  rst,
   input  wire logic  ce,
   // cycle length and end marker
   ebl_tick_if.timer  tk
);

   logic [2:0] cnt_reg;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cnt_reg <= ebl_pkg::RST_TNUM;
      end
      else if (ce)
      begin
         if (cnt_reg == tk.len)
         begin
            cnt_reg <= ebl_pkg::RST_TNUM;
         end
         else
         begin
            cnt_reg <= cnt_reg + 3'h1;
         end
      end
   end

   assign tk.last = (cnt_reg == tk.len);
   assign tk.tnum = cnt_reg;

endmodule : ebl_tstate_timer

//--- logic/ebl_load_exec.sv
// ebl_load_exec: fetch, decode and execute of part of the 8-bit load group
// assumes memory answers a read within the cycle, valid on its last state
`timescale 1ns/1ps
module ebl_load_exec (
   // clock and control
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ce,
   // register file values held outside, and interrupt inputs
   input  wire logic [15:0] index_reg_x,
   input  wire logic [15:0] index_reg_y,
   input  wire logic [15:0] pointer_pair_one,
   input  wire logic [15:0] pointer_pair_two,
   input  wire logic        int_enable_shadow,
   input  wire logic        int_accepted,
   // memory bus
   output logic      [15:0] mem_addr,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic             mem_m1,
   output logic      [7:0]  mem_wdata,
   input  wire logic [7:0]  mem_rdata,
   // architectural state
   output logic      [7:0]  acc,
   output logic      [7:0]  flags,
   output logic      [7:0]  int_vector_page,
   output logic      [7:0]  refresh_counter,
   output logic      [15:0] prog_counter,
   // per-instruction status
   output logic             instr_done,
   output logic             unsupported_op
);

   ebl_tick_if tk ();

   ebl_tstate_timer u_timer (
      .clock (clock),
      .rst   (rst),
      .ce    (ce),
      .tk    (tk.timer)
   );

   ebl_pkg::ebl_state_t state_reg;
   ebl_pkg::ebl_state_t state_next;

   logic [2:0]  len_reg;
   logic [2:0]  len_next;
   logic [15:0] pc_reg;
   logic [15:0] pc_next;
   logic [15:0] addr_reg;
   logic [15:0] addr_next;
   logic        rd_reg;
   logic        rd_next;
   logic        wr_reg;
   logic        wr_next;
   logic        m1_reg;
   logic        m1_next;
   logic [7:0]  wdata_reg;
   logic [7:0]  wdata_next;
   logic [7:0]  pfx_reg;
   logic [7:0]  disp_reg;
   logic [7:0]  lo_reg;
   logic        dir_store_reg;
   logic        dir_store_next;
   logic        use_y_reg;
   logic [7:0]  acc_reg;
   logic [7:0]  flags_reg;
   logic [7:0]  ivp_reg;
   logic [7:0]  rfc_reg;
   logic        done_reg;
   logic        done_next;
   logic        bad_reg;
   logic        bad_next;
   logic        int_seen_reg;
   logic        step;
   logic        go_fetch;
   logic        acc_load;
   logic [7:0]  acc_val;
   logic        flag_load;
   logic        ivp_load;
   logic        rfc_load;
   logic [7:0]  rfc_bumped;
   logic [7:0]  copy_val;

   // sign-extend and wrap; the index register itself is only read
   function automatic logic [15:0] idx_addr(input logic [15:0] base, input logic [7:0] d);
      idx_addr = base + {{8{d[7]}}, d};
   endfunction : idx_addr

   // bit 4 of the opcode picks the second pointer pair
   function automatic logic [15:0] ptr_sel(input logic [7:0] op, input logic [15:0] p1,
                                           input logic [15:0] p2);
      ptr_sel = op[4] ? p2 : p1;
   endfunction : ptr_sel

   function automatic logic is_special(input logic [7:0] op);
      is_special = (op == ebl_pkg::OP_LD_A_IVP) || (op == ebl_pkg::OP_LD_A_RFC) ||
                   (op == ebl_pkg::OP_LD_IVP_A) || (op == ebl_pkg::OP_LD_RFC_A);
   endfunction : is_special

   assign step       = ce && tk.last;
   assign tk.len     = len_reg;
   // only the low seven bits count, bit 7 stays as software left it
   assign rfc_bumped = {rfc_reg[7], rfc_reg[6:0] + 7'h01};
   assign copy_val   = (mem_rdata == ebl_pkg::OP_LD_A_IVP) ? ivp_reg : rfc_bumped;

   always_comb
   begin
      state_next     = state_reg;
      len_next       = len_reg;
      pc_next        = pc_reg;
      addr_next      = addr_reg;
      rd_next        = rd_reg;
      wr_next        = wr_reg;
      m1_next        = m1_reg;
      wdata_next     = wdata_reg;
      dir_store_next = dir_store_reg;
      done_next      = 1'b0;
      bad_next       = 1'b0;
      go_fetch       = 1'b0;
      acc_load       = 1'b0;
      acc_val        = acc_reg;
      flag_load      = 1'b0;
      ivp_load       = 1'b0;
      rfc_load       = 1'b0;
      if (step)
      begin
         unique case (state_reg)
            ebl_pkg::ST_FETCH:
            begin
               pc_next = pc_reg + 16'h0001;
               if (mem_rdata == ebl_pkg::OP_PFX_X || mem_rdata == ebl_pkg::OP_PFX_Y ||
                   mem_rdata == ebl_pkg::OP_PFX_E)
               begin
                  state_next = ebl_pkg::ST_FETCH_PFX;
                  addr_next  = pc_next;
                  len_next   = (mem_rdata == ebl_pkg::OP_PFX_E) ? ebl_pkg::T_SPECIAL
                                                                : ebl_pkg::T_FETCH;
               end
               else if (mem_rdata == ebl_pkg::OP_LD_A_P1 || mem_rdata == ebl_pkg::OP_LD_A_P2)
               begin
                  state_next = ebl_pkg::ST_MEM_RD;
                  len_next   = ebl_pkg::T_MEM;
                  addr_next  = ptr_sel(mem_rdata, pointer_pair_one, pointer_pair_two);
                  m1_next    = 1'b0;
               end
               else if (mem_rdata == ebl_pkg::OP_ST_A_P1 || mem_rdata == ebl_pkg::OP_ST_A_P2)
               begin
                  state_next = ebl_pkg::ST_MEM_WR;
                  len_next   = ebl_pkg::T_MEM;
                  addr_next  = ptr_sel(mem_rdata, pointer_pair_one, pointer_pair_two);
                  rd_next    = 1'b0;
                  wr_next    = 1'b1;
                  m1_next    = 1'b0;
                  wdata_next = acc_reg;
               end
               else if (mem_rdata == ebl_pkg::OP_LD_A_DIR || mem_rdata == ebl_pkg::OP_ST_A_DIR)
               begin
                  state_next     = ebl_pkg::ST_ADDR_LO;
                  len_next       = ebl_pkg::T_MEM;
                  addr_next      = pc_next;
                  m1_next        = 1'b0;
                  dir_store_next = (mem_rdata == ebl_pkg::OP_ST_A_DIR);
               end
               else
               begin
                  bad_next  = 1'b1;
                  done_next = 1'b1;
                  go_fetch  = 1'b1;
               end
            end
            ebl_pkg::ST_FETCH_PFX:
            begin
               pc_next = pc_reg + 16'h0001;
               if (pfx_reg != ebl_pkg::OP_PFX_E && mem_rdata == ebl_pkg::OP_ST_IDX_IMM)
               begin
                  state_next = ebl_pkg::ST_DISP;
                  len_next   = ebl_pkg::T_MEM;
                  addr_next  = pc_next;
                  m1_next    = 1'b0;
               end
               else if (pfx_reg == ebl_pkg::OP_PFX_E && is_special(mem_rdata))
               begin
                  done_next = 1'b1;
                  go_fetch  = 1'b1;
                  if (mem_rdata == ebl_pkg::OP_LD_A_IVP || mem_rdata == ebl_pkg::OP_LD_A_RFC)
                  begin
                     acc_load  = 1'b1;
                     acc_val   = copy_val;
                     flag_load = 1'b1;
                  end
                  ivp_load = (mem_rdata == ebl_pkg::OP_LD_IVP_A);
                  rfc_load = (mem_rdata == ebl_pkg::OP_LD_RFC_A);
               end
               else
               begin
                  bad_next  = 1'b1;
                  done_next = 1'b1;
                  go_fetch  = 1'b1;
               end
            end
            ebl_pkg::ST_DISP:
            begin
               pc_next    = pc_reg + 16'h0001;
               state_next = ebl_pkg::ST_IMM;
               len_next   = ebl_pkg::T_IDX_CALC;
               addr_next  = pc_next;
            end
            ebl_pkg::ST_IMM:
            begin
               pc_next    = pc_reg + 16'h0001;
               state_next = ebl_pkg::ST_MEM_WR;
               len_next   = ebl_pkg::T_MEM;
               addr_next  = idx_addr(use_y_reg ? index_reg_y : index_reg_x, disp_reg);
               rd_next    = 1'b0;
               wr_next    = 1'b1;
               wdata_next = mem_rdata;
            end
            ebl_pkg::ST_ADDR_LO:
            begin
               pc_next    = pc_reg + 16'h0001;
               state_next = ebl_pkg::ST_ADDR_HI;
               addr_next  = pc_next;
            end
            ebl_pkg::ST_ADDR_HI:
            begin
               pc_next   = pc_reg + 16'h0001;
               addr_next = {mem_rdata, lo_reg};
               if (dir_store_reg)
               begin
                  state_next = ebl_pkg::ST_MEM_WR;
                  rd_next    = 1'b0;
                  wr_next    = 1'b1;
                  wdata_next = acc_reg;
               end
               else
               begin
                  state_next = ebl_pkg::ST_MEM_RD;
               end
            end
            ebl_pkg::ST_MEM_RD:
            begin
               acc_load  = 1'b1;
               acc_val   = mem_rdata;
               done_next = 1'b1;
               go_fetch  = 1'b1;
            end
            ebl_pkg::ST_MEM_WR:
            begin
               done_next = 1'b1;
               go_fetch  = 1'b1;
            end
         endcase
         if (go_fetch)
         begin
            state_next = ebl_pkg::ST_FETCH;
            len_next   = ebl_pkg::T_FETCH;
            addr_next  = pc_next;
            rd_next    = 1'b1;
            wr_next    = 1'b0;
            m1_next    = 1'b1;
         end
      end
   end

   // sequencer and cycle length
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_reg     <= ebl_pkg::ST_FETCH;
         len_reg       <= ebl_pkg::T_FETCH;
         dir_store_reg <= 1'b0;
      end
      else if (ce)
      begin
         state_reg     <= state_next;
         len_reg       <= len_next;
         dir_store_reg <= dir_store_next;
      end
   end

   // program counter
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pc_reg <= ebl_pkg::RST_PC;
      end
      else if (ce)
      begin
         pc_reg <= pc_next;
      end
   end

   // bus outputs, held for a whole machine cycle
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         addr_reg  <= ebl_pkg::RST_PC;
         rd_reg    <= 1'b1;
         wr_reg    <= 1'b0;
         m1_reg    <= 1'b1;
         wdata_reg <= 8'h00;
      end
      else if (ce)
      begin
         addr_reg  <= addr_next;
         rd_reg    <= rd_next;
         wr_reg    <= wr_next;
         m1_reg    <= m1_next;
         wdata_reg <= wdata_next;
      end
   end

   // operand capture
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pfx_reg   <= 8'h00;
         disp_reg  <= 8'h00;
         lo_reg    <= 8'h00;
         use_y_reg <= 1'b0;
      end
      else if (step)
      begin
         if (state_reg == ebl_pkg::ST_FETCH)
         begin
            pfx_reg   <= mem_rdata;
            use_y_reg <= (mem_rdata == ebl_pkg::OP_PFX_Y);
         end
         if (state_reg == ebl_pkg::ST_DISP)
         begin
            disp_reg <= mem_rdata;
         end
         if (state_reg == ebl_pkg::ST_ADDR_LO)
         begin
            lo_reg <= mem_rdata;
         end
      end
   end

   // accumulator
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         acc_reg <= ebl_pkg::RST_ACC;
      end
      else if (ce && acc_load)
      begin
         acc_reg <= acc_val;
      end
   end

   // flags move only on the two special copies
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         flags_reg <= ebl_pkg::RST_FLAGS;
      end
      else if (ce && flag_load)
      begin
         flags_reg[ebl_pkg::FLAG_S] <= copy_val[7];
         flags_reg[ebl_pkg::FLAG_Z] <= (copy_val == 8'h00);
         flags_reg[ebl_pkg::FLAG_H] <= 1'b0;
         flags_reg[ebl_pkg::FLAG_N] <= 1'b0;
         flags_reg[ebl_pkg::FLAG_PV] <= int_enable_shadow && !int_seen_reg && !int_accepted;
      end
   end

   // interrupt seen since the last opcode fetch began; a new accept wins
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         int_seen_reg <= 1'b0;
      end
      else if (ce)
      begin
         int_seen_reg <= int_accepted || (int_seen_reg && !(step && go_fetch));
      end
   end

   // vector page and refresh counter
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ivp_reg <= ebl_pkg::RST_IVP;
         rfc_reg <= ebl_pkg::RST_RFC;
      end
      else if (ce)
      begin
         if (ivp_load)
         begin
            ivp_reg <= acc_reg;
         end
         if (rfc_load)
         begin
            rfc_reg <= acc_reg;
         end
         else if (step && m1_reg)
         begin
            rfc_reg <= rfc_bumped;
         end
      end
   end

   // completion pulses
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         done_reg <= 1'b0;
         bad_reg  <= 1'b0;
      end
      else if (ce)
      begin
         done_reg <= done_next;
         bad_reg  <= bad_next;
      end
   end

   assign mem_addr        = addr_reg;
   assign mem_rd          = rd_reg;
   assign mem_wr          = wr_reg;
   assign mem_m1          = m1_reg;
   assign mem_wdata       = wdata_reg;
   assign acc             = acc_reg;
   assign flags           = flags_reg;
   assign int_vector_page = ivp_reg;
   assign refresh_counter = rfc_reg;
   assign prog_counter    = pc_reg;
   assign instr_done      = done_reg;
   assign unsupported_op  = bad_reg;

endmodule : ebl_load_exec

//--- sim/ebl_mem_model.sv
// ebl_mem_model: byte memory on the executor's address/data bus
// assumes reads are combinational and writes land on each write state
`timescale 1ns/1ps
module ebl_mem_model (
   // clock
   input  wire logic        clock,
   // bus from the executor
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic [7:0]  mem_wdata,
   // read data back
   output logic      [7:0]  mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] idle_pat = 8'h00;

   // read byte stands, no wait states
   assign mem_rdata = mem_rd ? mem[mem_addr] : idle_pat;

   // outside reads the bus wanders, so a stale byte never looks valid
   always @(posedge clock)
      idle_pat <= idle_pat + 8'h35;

   always @(posedge clock)
      if (mem_wr)
         mem[mem_addr] <= mem_wdata;
endmodule : ebl_mem_model

//--- sim/ebl_load_exec_asserts.sv
// ebl_load_exec_asserts: port-level checks of the load executor
// assumes ce is dropped only inside an opcode fetch
`timescale 1ns/1ps
module ebl_load_exec_asserts (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // memory bus
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic        mem_m1,
   input  wire logic [7:0]  mem_wdata,
   // state and status
   input  wire logic [7:0]  acc,
   input  wire logic [7:0]  flags,
   input  wire logic [7:0]  int_vector_page,
   input  wire logic        instr_done
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   wire carry = flags[ebl_pkg::FLAG_C];

   sequence s_write;
      mem_wr[*3] ##1 !mem_wr;
   endsequence

   a_wr_three_states: assert property ($rose(mem_wr) |-> s_write)
      else $error("write cycle not three states");
   a_wr_held_steady: assert property (mem_wr && $past(mem_wr) |->
      $stable(mem_addr) && $stable(mem_wdata)) else $error("write address or data moved");
   a_rd_wr_apart: assert property (!(mem_rd && mem_wr))
      else $error("read and write together");
   a_fetch_reads: assert property (mem_m1 |-> mem_rd && !mem_wr)
      else $error("fetch cycle not a read");
   a_done_one_cycle: assert property (instr_done |=> !instr_done)
      else $error("done pulse too long");
   a_acc_at_done: assert property ($changed(acc) |-> instr_done)
      else $error("acc changed outside completion");
   a_flags_at_done: assert property ($changed(flags) |-> instr_done)
      else $error("flags changed outside completion");
   a_flags_cleared: assert property ($changed(flags) |-> $stable(carry) &&
      !flags[ebl_pkg::FLAG_H] && !flags[ebl_pkg::FLAG_N]) else $error("h n c wrong");
   a_sign_zero: assert property ($changed(flags) |-> flags[ebl_pkg::FLAG_S] == acc[7] &&
      flags[ebl_pkg::FLAG_Z] == (acc == 8'h00)) else $error("sign or zero wrong");
   a_page_from_acc: assert property ($changed(int_vector_page) |-> instr_done &&
      int_vector_page == $past(acc)) else $error("vector page not from acc");
endmodule : ebl_load_exec_asserts

bind ebl_load_exec ebl_load_exec_asserts chk_u (.clock(clock), .rst(rst),
   .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_m1(mem_m1),
   .mem_wdata(mem_wdata),
   .acc(acc), .flags(flags), .int_vector_page(int_vector_page), .instr_done(instr_done));

//--- sim/tb_top.sv
// tb_top: runs a short program through the load executor and checks results
// assumes the memory model answers every read without wait states
`timescale 1ns/1ps
module tb_top;
   logic        clock, rst, ce, int_enable_shadow, int_accepted;
   logic [15:0] index_reg_x, index_reg_y, pointer_pair_one, pointer_pair_two;
   logic [15:0] mem_addr, prog_counter, pc_tb;
   logic [7:0]  mem_wdata, mem_rdata, acc, flags, int_vector_page, refresh_counter;
   logic        mem_rd, mem_wr, mem_m1, instr_done, unsupported_op;
   int          fail_count = 0;
   int          checks_done = 0;
   int          cyc = 0;

   ebl_load_exec dut_u (.clock(clock), .rst(rst), .ce(ce), .index_reg_x(index_reg_x),
      .index_reg_y(index_reg_y), .pointer_pair_one(pointer_pair_one),
      .pointer_pair_two(pointer_pair_two), .int_enable_shadow(int_enable_shadow),
      .int_accepted(int_accepted), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_m1(mem_m1), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .acc(acc),
      .flags(flags), .int_vector_page(int_vector_page), .refresh_counter(refresh_counter),
      .prog_counter(prog_counter), .instr_done(instr_done), .unsupported_op(unsupported_op));

   ebl_mem_model mem_u (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop

   // a hang in the bench or design must still reach the report
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         fail_count++;
         $display("ERROR %0t: run too long", $time);
         report_and_stop();
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t: word %h, expected %h", $time, got, exp);
      end
   endtask : chk16

   task automatic chkn(input int got, input int exp);
      checks_done++;
      if (got != exp)
      begin
         fail_count++;
         $display("ERROR %0t: %0d states, expected %0d", $time, got, exp);
      end
   endtask : chkn

   // places code at the next address, runs it, checks its state count;
   // stl freezes ce for that many states right after the opcode fetch begins
   task automatic exec(input logic [31:0] code, input int nb, input int ns,
                       input int stl, input logic sh, input logic ia);
      int n;
      n = 0;
      for (int i = 0; i < nb; i++)
         mem_u.mem[pc_tb + 16'(i)] = code[31 - 8 * i -: 8];
      pc_tb = pc_tb + 16'(nb);
      while (n == 0 || (instr_done !== 1'b1 && n < 100))
      begin
         @(posedge clock);
         ce <= (n >= stl);
         int_enable_shadow <= sh;
         int_accepted <= ia;
         @(negedge clock);
         n++;
      end
      if (ns > 0)
         chkn(n, ns + stl);
      $display("test done at %0t, %0d states", $time, n);
   endtask : exec

   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      int_enable_shadow = 1'b0;
      int_accepted = 1'b0;
      index_reg_x = 16'h219a;
      index_reg_y = 16'h0005;
      pointer_pair_one = 16'h4747;
      pointer_pair_two = 16'h30a2;
      mem_u.mem[16'h0000] = 8'h00;
      mem_u.mem[16'h8832] = 8'h80;
      mem_u.mem[16'h4747] = 8'h00;
      mem_u.mem[16'h30a2] = 8'h22;
      mem_u.mem[16'h9000] = 8'h00;
      pc_tb = 16'h0001;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      exec(32'h0, 0, 0, 0, 1'b0, 1'b0);
      chk8({7'h00, unsupported_op}, 8'h01);
      exec(32'h3a328800, 3, 13, 0, 1'b0, 1'b0);
      chk8(acc, 8'h80);
      chk8({7'h00, unsupported_op}, 8'h00);
      chk16(prog_counter, 16'h0004);
      chk8(flags, 8'hff);
      exec(32'hed470000, 2, 9, 0, 1'b0, 1'b0);
      chk8(int_vector_page, 8'h80);
      exec(32'h0a000000, 1, 7, 3, 1'b0, 1'b0);
      chk8(acc, 8'h00);
      exec(32'hed570000, 2, 9, 0, 1'b0, 1'b0);
      chk8(acc, 8'h80);
      chk8(flags, 8'ha9);
      exec(32'h1a000000, 1, 7, 0, 1'b1, 1'b0);
      chk8(acc, 8'h22);
      exec(32'h02000000, 1, 7, 0, 1'b1, 1'b0);
      chk8(mem_u.mem[16'h4747], 8'h22);
      exec(32'hed4f0000, 2, 9, 0, 1'b1, 1'b0);
      chk8(refresh_counter, 8'h22);
      exec(32'hed5f0000, 2, 9, 0, 1'b1, 1'b1);
      chk8(acc, 8'h24);
      chk8(flags, 8'h29);
      exec(32'h12000000, 1, 7, 0, 1'b0, 1'b0);
      chk8(mem_u.mem[16'h30a2], 8'h24);
      exec(32'hdd36055a, 4, 19, 0, 1'b0, 1'b0);
      chk8(mem_u.mem[16'h219f], 8'h5a);
      chk16(prog_counter, 16'h0014);
      exec(32'hfd36f097, 4, 19, 0, 1'b0, 1'b0);
      chk8(mem_u.mem[16'hfff5], 8'h97);
      chk8(flags, 8'h29);
      exec(32'h32413100, 3, 13, 0, 1'b0, 1'b0);
      chk8(mem_u.mem[16'h3141], 8'h24);
      exec(32'h3a009000, 3, 13, 0, 1'b0, 1'b0);
      exec(32'hed470000, 2, 9, 0, 1'b0, 1'b0);
      chk8(int_vector_page, 8'h00);
      exec(32'hed570000, 2, 9, 0, 1'b1, 1'b0);
      chk8(acc, 8'h00);
      chk8(flags, 8'h6d);
      report_and_stop();
   end
endmodule : tb_top
